//--- common/rrc_pkg.sv
// Constants, register map and carrier types for the reset and reference clock request controller.
// Assumes a single 10 MHz core clock; slower rates are one-cycle enable pulses, except the slow clock input, which is a level.

package rrc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_KHZ       = 10000;
	localparam int STAB_TIME_US       = 5000;
	localparam int STAB_CYCLES        = STAB_TIME_US * CLK_FREQ_KHZ / 1000;
	localparam int SETTLE_TIME_US     = 1200;
	localparam int SETTLE_SLOW_CYCLES = 40;
	localparam int INT_OSC_FREQ_HZ    = 32768;
	localparam int INT_OSC_DIV        = CLK_FREQ_KHZ * 1000 / INT_OSC_FREQ_HZ;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_AUX = 4;
	localparam int NUM_REQ = 3;
	localparam int DIV_W   = 4;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [4:0]  REG_MAP    = 5'h00;
	localparam logic [4:0]  REG_POL    = 5'h04;
	localparam logic [4:0]  REG_SRC    = 5'h08;
	localparam logic [4:0]  REG_DIV    = 5'h0c;
	localparam logic [4:0]  REG_STATUS = 5'h10;
	localparam logic [4:0]  REG_FREQ   = 5'h14;
	localparam logic [4:0]  REG_OSC    = 5'h18;
	localparam logic [7:0]  MAP_RST    = 8'he4;
	localparam logic [2:0]  POL_RST    = 3'h7;
	localparam logic [7:0]  SRC_RST    = 8'h00;
	localparam logic [15:0] DIV_RST    = 16'h0000;
	localparam logic [2:0]  FREQ_RST   = 3'h0;
	localparam logic [2:0]  FREQ_MAX   = 3'h4;
	localparam logic [1:0]  REQ_NONE   = 2'h3;
	localparam int          SRC_BALL_BIT = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_SYS = 2'h0, SRC_CORE = 2'h1, SRC_PER = 2'h2} rrc_src_e;
	typedef enum logic [1:0] {SEQ_POR, SEQ_STAB, SEQ_SETTLE, SEQ_RUN} rrc_seq_e;

	typedef struct packed {
		logic [7:0]  reqMap;
		logic [2:0]  reqPol;
		logic [7:0]  auxSrc;
		logic        ballIsOut3;
		logic [15:0] auxDiv;
		logic [2:0]  freqCode;
	} rrc_cfg_s;

endpackage : rrc_pkg

//--- core/rrc_slow_edge.sv
// Rising-edge detector for the slow clock input, giving a one-cycle tick.
// Assumes the slow clock input is already synchronous to core_clk.
`timescale 1ns/10ps
module rrc_slow_edge (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// Slow clock
	input  wire logic slowClockInput,
	output logic      slowTick
);

	logic slowPrev_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			slowPrev_reg <= 1'b0;
		end else begin
			slowPrev_reg <= slowClockInput;
		end
	end

	assign slowTick = slowClockInput & ~slowPrev_reg;

endmodule : rrc_slow_edge

//--- core/rrc_aux_div.sv
// One auxiliary clock channel: divides its selected source tick and gates the result.
// Assumes the source tick is a one-cycle enable pulse in the core_clk domain.
`timescale 1ns/10ps
module rrc_aux_div #(
	parameter int DW = 4
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rstn,
	// Control
	input  wire logic          srcTick,
	input  wire logic [DW-1:0] divVal,
	input  wire logic          gateOpen,
	// Output
	output logic               auxClk
);

	logic [DW-1:0] cnt_reg;

	// Closing the gate parks the output low on the next edge, cutting short any high phase in progress.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			auxClk  <= 1'b0;
		end else if (!gateOpen) begin
			cnt_reg <= '0;
			auxClk  <= 1'b0;
		end else if (srcTick) begin
			if (cnt_reg >= divVal) begin
				cnt_reg <= '0;
				auxClk  <= ~auxClk;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule : rrc_aux_div

//--- core/rrc_top.sv
// Reset release sequencer, clock request pin and four gated auxiliary clocks.
// Assumes synchronous pin inputs, an Avalon-MM master and 10 MHz core_clk.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
module rrc_top #(
	parameter int STAB_CYC = rrc_pkg::STAB_CYCLES,
	parameter int DW       = rrc_pkg::DIV_W
) (
	// Clock and block reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Avalon-MM slave
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// Power-on reset, warm reset and boot straps
	input  wire logic        powerOnResetN,
	output logic             warmResetN,
	input  wire logic [1:0]  bootCfg,
	// Clock sources as enable pulses; the slow clock comes in as a level
	input  wire logic        slowClockInput,
	input  wire logic        sysClkTick,
	input  wire logic        corePllTick,
	input  wire logic        peripheralPllTick,
	output logic             intSlowTick,
	// System clock request pin
	input  wire logic        clkReqPadIn,
	output logic             clkReqPadOut,
	output logic             clkReqPadOe,
	// Auxiliary requests and clocks
	input  wire logic        auxClkRequest1,
	input  wire logic        auxClkRequest2BallIn,
	output logic             auxClkRequest2BallOut,
	output logic             auxClkRequest2BallOe,
	output logic [2:0]       auxClkOutput
);

	// ----------------------------------------------------------------
	// Declarations and helpers
	// ----------------------------------------------------------------
	rrc_pkg::rrc_cfg_s cfg_reg;
	rrc_pkg::rrc_seq_e seq_reg;
	logic [31:0]       stabCnt_reg;
	logic [5:0]        slowCnt_reg;
	logic [1:0]        boot_reg;
	logic              ack_reg;
	logic [15:0]       oscCnt_reg;
	logic [15:0]       oscTicks_reg;
	logic              slowTick;
	logic [2:0]        reqRaw;
	logic [2:0]        reqAct;
	logic [3:0]        gateOpen;
	logic [3:0]        auxClk;
	logic              busWr;
	logic              bootOsc;
	logic [31:0]       wrOld;
	logic [31:0]       wrMerged;

	function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
			input logic [31:0] newV, input logic [3:0] be);
		logic [31:0] res;
		res = oldV;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = newV[8*b +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	function automatic logic pickReq(input logic [1:0] sel, input logic [2:0] act);
		logic res;
		res = 1'b0;
		if (sel != rrc_pkg::REQ_NONE) begin
			res = act[sel];
		end
		return res;
	endfunction : pickReq

	function automatic logic pickSrc(input logic [1:0] sel, input logic s, input logic c,
			input logic p);
		logic res;
		res = 1'b0;
		unique case (sel)
			rrc_pkg::SRC_SYS:  res = s;
			rrc_pkg::SRC_CORE: res = c;
			rrc_pkg::SRC_PER:  res = p;
			default:           res = 1'b0;
		endcase
		return res;
	endfunction : pickSrc

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	// Every access takes one wait cycle so read data can come from a flip-flop.
	assign waitrequest = (read | write) & ~ack_reg;
	assign busWr       = write & ack_reg;

	// Partial byte writes keep the untouched bytes of the addressed register.
	always_comb begin
		unique case (address)
			rrc_pkg::REG_MAP: wrOld = {24'h000000, cfg_reg.reqMap};
			rrc_pkg::REG_POL: wrOld = {29'h0000000, cfg_reg.reqPol};
			rrc_pkg::REG_SRC: wrOld = {23'h000000, cfg_reg.ballIsOut3, cfg_reg.auxSrc};
			rrc_pkg::REG_DIV: wrOld = {16'h0000, cfg_reg.auxDiv};
			default:          wrOld = 32'h0000_0000;
		endcase
	end

	assign wrMerged = mergeBytes(wrOld, writedata, byteenable);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read | write) & ~ack_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack_reg) begin
			unique case (address)
				rrc_pkg::REG_MAP:    readdata <= {24'h000000, cfg_reg.reqMap};
				rrc_pkg::REG_POL:    readdata <= {29'h00000000, cfg_reg.reqPol};
				rrc_pkg::REG_SRC:    readdata <= {23'h000000, cfg_reg.ballIsOut3,
					cfg_reg.auxSrc};
				rrc_pkg::REG_DIV:    readdata <= {16'h0000, cfg_reg.auxDiv};
				rrc_pkg::REG_STATUS: readdata <= {22'h000000, auxClkRequest2BallOe ? auxClk[3]
					: 1'b0, auxClk[2:0], boot_reg, seq_reg, clkReqPadOe, warmResetN};
				rrc_pkg::REG_FREQ:   readdata <= {29'h00000000, cfg_reg.freqCode};
				rrc_pkg::REG_OSC:    readdata <= {16'h0000, oscTicks_reg};
				default:             readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg.reqMap     <= rrc_pkg::MAP_RST;
			cfg_reg.reqPol     <= rrc_pkg::POL_RST;
			cfg_reg.auxSrc     <= rrc_pkg::SRC_RST;
			cfg_reg.ballIsOut3 <= 1'b0;
			cfg_reg.auxDiv     <= rrc_pkg::DIV_RST;
			cfg_reg.freqCode   <= rrc_pkg::FREQ_RST;
		end else if (busWr) begin
			unique case (address)
				rrc_pkg::REG_MAP: cfg_reg.reqMap <= wrMerged[7:0];
				rrc_pkg::REG_POL: cfg_reg.reqPol <= wrMerged[2:0];
				rrc_pkg::REG_SRC: {cfg_reg.ballIsOut3, cfg_reg.auxSrc} <= wrMerged[8:0];
				rrc_pkg::REG_DIV: cfg_reg.auxDiv <= wrMerged[15:0];
				rrc_pkg::REG_FREQ: begin
					// Codes outside the five supported rates are ignored.
					if (byteenable[0] && writedata[2:0] <= rrc_pkg::FREQ_MAX) begin
						cfg_reg.freqCode <= writedata[2:0];
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Reset release sequencer
	// ----------------------------------------------------------------
	rrc_slow_edge u_slow_edge (
		.core_clk       (core_clk),
		.rstn           (rstn),
		.slowClockInput (slowClockInput),
		.slowTick       (slowTick)
	);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seq_reg     <= rrc_pkg::SEQ_POR;
			stabCnt_reg <= 32'h0000_0000;
			slowCnt_reg <= 6'h00;
			warmResetN  <= 1'b0;
		end else if (!powerOnResetN) begin
			seq_reg     <= rrc_pkg::SEQ_POR;
			stabCnt_reg <= 32'h0000_0000;
			slowCnt_reg <= 6'h00;
			warmResetN  <= 1'b0;
		end else begin
			unique case (seq_reg)
				rrc_pkg::SEQ_POR: begin
					seq_reg <= rrc_pkg::SEQ_STAB;
				end
				rrc_pkg::SEQ_STAB: begin
					if (stabCnt_reg == 32'(STAB_CYC - 1)) begin
						seq_reg <= rrc_pkg::SEQ_SETTLE;
					end else begin
						stabCnt_reg <= stabCnt_reg + 32'h1;
					end
				end
				rrc_pkg::SEQ_SETTLE: begin
					if (slowTick) begin
						if (slowCnt_reg == 6'(rrc_pkg::SETTLE_SLOW_CYCLES - 1)) begin
							seq_reg    <= rrc_pkg::SEQ_RUN;
							warmResetN <= 1'b1;
						end else begin
							slowCnt_reg <= slowCnt_reg + 6'h1;
						end
					end
				end
				rrc_pkg::SEQ_RUN: ;
			endcase
		end
	end

	// Straps are caught while power-on reset holds, never by the async reset.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			boot_reg <= 2'h0;
		end else if (seq_reg == rrc_pkg::SEQ_POR) begin
			boot_reg <= bootCfg;
		end
	end

	// ----------------------------------------------------------------
	// Internal free-running slow oscillator
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			oscCnt_reg   <= 16'h0000;
			oscTicks_reg <= 16'h0000;
		end else if (oscCnt_reg == 16'(rrc_pkg::INT_OSC_DIV - 1)) begin
			oscCnt_reg   <= 16'h0000;
			oscTicks_reg <= oscTicks_reg + 16'h1;
		end else begin
			oscCnt_reg <= oscCnt_reg + 16'h1;
		end
	end

	assign intSlowTick = (oscCnt_reg == 16'(rrc_pkg::INT_OSC_DIV - 1));

	// ----------------------------------------------------------------
	// Request pin and auxiliary request decoding
	// ----------------------------------------------------------------
	assign bootOsc      = (boot_reg == 2'h0);
	// Pad drives only while requesting; the board pull holds the idle level.
	assign clkReqPadOe  = !bootOsc && (seq_reg != rrc_pkg::SEQ_POR);
	assign clkReqPadOut = cfg_reg.reqPol[0];

	assign reqRaw[0] = bootOsc ? clkReqPadIn : ~cfg_reg.reqPol[0];
	assign reqRaw[1] = auxClkRequest1;
	assign reqRaw[2] = cfg_reg.ballIsOut3 ? ~cfg_reg.reqPol[2]
		: auxClkRequest2BallIn;
	assign reqAct    = reqRaw ~^ cfg_reg.reqPol;

	assign auxClkRequest2BallOe  = cfg_reg.ballIsOut3;
	assign auxClkRequest2BallOut = auxClk[3];
	assign auxClkOutput          = auxClk[2:0];

	// ----------------------------------------------------------------
	// Auxiliary clock channels
	// ----------------------------------------------------------------
	for (genvar y = 0; y < rrc_pkg::NUM_AUX; y++) begin : g_aux
		assign gateOpen[y] = pickReq(cfg_reg.reqMap[2*y +: 2], reqAct);

		rrc_aux_div #(
			.DW (DW)
		) u_div (
			.core_clk (core_clk),
			.rstn     (rstn),
			.srcTick  (pickSrc(cfg_reg.auxSrc[2*y +: 2], sysClkTick, corePllTick,
				peripheralPllTick)),
			.divVal   (cfg_reg.auxDiv[4*y +: DW]),
			.gateOpen (gateOpen[y]),
			.auxClk   (auxClk[y])
		);

		AST_GATE_CLOSED: assert property (@(posedge core_clk) disable iff (!rstn)
			!gateOpen[y] |=> !auxClk[y])
			else $error("aux clock runs with its request inactive");
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence sqStabEnd;
		seq_reg == rrc_pkg::SEQ_STAB && stabCnt_reg == 32'(STAB_CYC - 1) && powerOnResetN;
	endsequence

	sequence sqSettleEnd;
		seq_reg == rrc_pkg::SEQ_SETTLE && slowTick && powerOnResetN
			&& slowCnt_reg == 6'(rrc_pkg::SETTLE_SLOW_CYCLES - 1);
	endsequence

	AST_REQ_RAISE: assert property (@(posedge core_clk) disable iff (!rstn)
		(seq_reg == rrc_pkg::SEQ_POR && powerOnResetN && boot_reg != 2'h0)
		|=> clkReqPadOe)
		else $error("clock request not raised after power-on reset release");

	AST_STAB_TIME: assert property (@(posedge core_clk) disable iff (!rstn)
		sqStabEnd |=> seq_reg == rrc_pkg::SEQ_SETTLE && !warmResetN)
		else $error("stabilisation window did not end on its count");

	AST_STAB_EARLY: assert property (@(posedge core_clk) disable iff (!rstn)
		(seq_reg == rrc_pkg::SEQ_STAB && powerOnResetN
		&& stabCnt_reg != 32'(STAB_CYC - 1)) |=> seq_reg == rrc_pkg::SEQ_STAB)
		else $error("stabilisation window ended early");

	AST_WARM_RELEASE: assert property (@(posedge core_clk) disable iff (!rstn)
		sqSettleEnd |=> warmResetN ##1 warmResetN || !$past(powerOnResetN))
		else $error("warm reset not released after settle count");

	AST_WARM_ONLY_RUN: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(warmResetN) |-> $past(seq_reg) == rrc_pkg::SEQ_SETTLE && $past(slowTick))
		else $error("warm reset released outside settle end");

	AST_POR_RESTART: assert property (@(posedge core_clk) disable iff (!rstn)
		!powerOnResetN |=> !warmResetN && seq_reg == rrc_pkg::SEQ_POR && !clkReqPadOe)
		else $error("power-on reset did not restart the sequence");

	AST_OSC_NO_REQ: assert property (@(posedge core_clk) disable iff (!rstn)
		boot_reg == 2'h0 |-> !clkReqPadOe)
		else $error("request driven while oscillator selected");

	AST_PAD_LEVEL: assert property (@(posedge core_clk) disable iff (!rstn)
		clkReqPadOe |-> clkReqPadOut == cfg_reg.reqPol[0])
		else $error("request pin driven at the wrong level");

	AST_BALL_SHARE: assert property (@(posedge core_clk) disable iff (!rstn)
		auxClkRequest2BallOe |-> !reqAct[2])
		else $error("shared ball used as request and clock at once");

	AST_FREQ_LEGAL: assert property (@(posedge core_clk) disable iff (!rstn)
		cfg_reg.freqCode <= rrc_pkg::FREQ_MAX)
		else $error("unsupported system clock rate code held");

	AST_BUS_ANSWER: assert property (@(posedge core_clk) disable iff (!rstn)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("bus access not answered in one wait cycle");

endmodule : rrc_top

//--- tb/rrc_partner.sv
// Model of the power manager and reference clock source facing the request controller.
// Assumes the bench commands power-on reset release and picks the board pull on the pin.
`timescale 1ns/10ps
module rrc_partner (
	// Clock and bench commands
	input  wire logic core_clk,
	input  wire logic porRelease,
	input  wire logic pullUp,
	input  wire logic extDrive,
	input  wire logic extLevel,
	// Device pins
	input  wire logic padOut,
	input  wire logic padOe,
	output logic      padIn,
	output logic      powerOnResetN,
	output logic      slowClockInput,
	output logic      sysClkTick
);
	// Wakeup, core and processor/multimedia supplies, lowest bit first.
	logic [2:0] supplyOn  = 3'h0;
	logic [3:0] slowCnt   = 4'h0;
	logic       slowLevel = 1'b0;
	logic       porSync   = 1'b0;
	logic       sysTick   = 1'b0;

	// Each supply waits for the one below it; none is dropped while the run lasts.
	always @(posedge core_clk) begin
		supplyOn <= {supplyOn[1:0], 1'b1};
	end

	// The slow clock runs from power-up, so it is stable before reset is released.
	always @(posedge core_clk) begin
		slowCnt <= slowCnt + 4'h1;
		if (slowCnt == 4'hf)
			slowLevel <= ~slowLevel;
	end

	// Reset falls with the clock stop, and the clock is clean from its first tick.
	// The square clock is taken as if through the slicer in active mode.
	always @(posedge core_clk) begin
		porSync <= porRelease & supplyOn[2];
		sysTick <= porRelease & ~sysTick;
	end

	assign powerOnResetN  = porSync;
	assign slowClockInput = slowLevel;
	assign sysClkTick     = sysTick;

	// A released pin rests at the board pull level, or at extLevel while extDrive is set.
	assign padIn = padOe ? padOut : (extDrive ? extLevel : pullUp);
endmodule : rrc_partner

//--- tb/tb_reset_and_refclk_request_ctrl.sv
// Self-checking bench for the reset release sequencer and auxiliary clock gating.
// Assumes the partner model supplies reset, slow clock and system clock ticks.
`timescale 1ns/10ps
module tb_reset_and_refclk_request_ctrl;
	localparam int STAB = 20;
	logic        core_clk, rstn, read, write, porRelease, pullUp, extDrive, extLevel;
	logic [4:0]  address;
	logic [31:0] writedata, readdata, rdVal;
	logic [3:0]  byteenable;
	logic [1:0]  bootCfg;
	logic [2:0]  auxClkOutput;
	logic        waitrequest, warmResetN, powerOnResetN, slowClockInput, sysClkTick;
	logic        peripheralPllTick, padIn, padOut, padOe, auxClkRequest1, ballIn, ballOut, ballOe;
	logic        corePllTick, intSlowTick;
	int          errors, samples_checked;

	rrc_top #(.STAB_CYC(STAB)) i_dut (.core_clk(core_clk), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .powerOnResetN(powerOnResetN),
		.warmResetN(warmResetN), .bootCfg(bootCfg), .slowClockInput(slowClockInput),
		.sysClkTick(sysClkTick), .corePllTick(corePllTick), .peripheralPllTick(peripheralPllTick),
		.intSlowTick(intSlowTick), .clkReqPadIn(padIn), .clkReqPadOut(padOut), .clkReqPadOe(padOe),
		.auxClkRequest1(auxClkRequest1), .auxClkRequest2BallIn(ballIn),
		.auxClkRequest2BallOut(ballOut), .auxClkRequest2BallOe(ballOe),
		.auxClkOutput(auxClkOutput));
	rrc_partner i_partner (.core_clk(core_clk), .porRelease(porRelease), .pullUp(pullUp),
		.extDrive(extDrive), .extLevel(extLevel), .padOut(padOut), .padOe(padOe),
		.padIn(padIn), .powerOnResetN(powerOnResetN), .slowClockInput(slowClockInput),
		.sysClkTick(sysClkTick));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// The request is held until the rising edge at which waitrequest is seen low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0);
		rdVal = readdata;
		chk("bus wait edges", 2, n);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(what, exp, rdVal & m);
	endtask : rd_chk

	// Counts output changes over eight cycles; a closed gate must also hold the output low.
	task automatic aux_run(input string what, input int idx, input int exp);
		logic prev, cur;
		int   n;
		n = 0;
		repeat (4) @(negedge core_clk);
		prev = (idx == 3) ? ballOut : auxClkOutput[idx];
		repeat (8) begin
			@(negedge core_clk);
			cur = (idx == 3) ? ballOut : auxClkOutput[idx];
			if (cur !== prev)
				n++;
			prev = cur;
		end
		chk(what, exp, n);
		if (exp == 0)
			chk(what, 0, cur);
	endtask : aux_run

	task automatic por_release(input logic [1:0] b);
		@(posedge slowClockInput);
		@(posedge core_clk);
		bootCfg <= b;
		porRelease <= 1'b1;
	endtask : por_release

	task automatic por_assert();
		@(posedge core_clk);
		porRelease <= 1'b0;
		repeat (3) @(negedge core_clk);
	endtask : por_assert

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("warm held", 0, warmResetN);
		chk("req oe in por", 0, padOe);
		rd_chk("map reset", 5'h00, 32'hff, 32'he4);
		rd_chk("pol reset", 5'h04, 32'h7, 32'h7);
		bus(1'b1, 5'h1c, 32'hffff_ffff);
		rd_chk("unmapped", 5'h1c, 32'hffff_ffff, 32'h0);
		bus(1'b1, 5'h14, 32'h5);
		rd_chk("freq refused", 5'h14, 32'h7, 32'h0);
		bus(1'b1, 5'h14, 32'h4);
		rd_chk("freq kept", 5'h14, 32'h7, 32'h4);
	endtask : t_reset

	// Measures the internal oscillator tick spacing in core cycles.
	task automatic t_osc();
		int n;
		n = 0;
		do @(negedge core_clk); while (intSlowTick !== 1'b1);
		do begin
			@(negedge core_clk);
			n++;
		end while (intSlowTick !== 1'b1);
		chk("osc period", rrc_pkg::INT_OSC_DIV, n);
	endtask : t_osc

	task automatic t_abort();
		por_release(2'h1);
		repeat (10) @(posedge slowClockInput);
		rd_chk("seq settle", 5'h10, 32'hc, 32'h8);
		por_assert();
		chk("req oe dropped", 0, padOe);
		chk("warm held", 0, warmResetN);
		rd_chk("seq restart", 5'h10, 32'hc, 32'h0);
	endtask : t_abort

	task automatic t_powerup();
		por_release(2'h1);
		repeat (10) @(negedge core_clk);
		chk("req oe", 1, padOe);
		chk("req level", 1, padOut);
		rd_chk("seq stab", 5'h10, 32'h3c, 32'h14);
		repeat (10) @(negedge core_clk);
		rd_chk("seq settle", 5'h10, 32'hc, 32'h8);
		repeat (40) @(posedge slowClockInput);
		@(negedge core_clk);
		chk("warm early", 0, warmResetN);
		@(negedge core_clk);
		chk("warm released", 1, warmResetN);
	endtask : t_powerup

	task automatic t_aux();
		aux_run("aux1 open", 1, 4);
		aux_run("aux2 open", 2, 4);
		aux_run("aux0 refused", 0, 0);
		@(posedge core_clk);
		auxClkRequest1 <= 1'b0;
		aux_run("aux1 closed", 1, 0);
		bus(1'b1, 5'h04, 32'h5);
		aux_run("aux1 low active", 1, 4);
		bus(1'b1, 5'h04, 32'h7);
		bus(1'b1, 5'h00, 32'hd4);
		ballIn <= 1'b0;
		auxClkRequest1 <= 1'b1;
		aux_run("aux2 remapped", 2, 4);
		bus(1'b1, 5'h08, 32'h100);
		bus(1'b1, 5'h00, 32'h64);
		chk("ball oe", 1, ballOe);
		aux_run("aux3 on ball", 3, 4);
		bus(1'b1, 5'h08, 32'h108);
		peripheralPllTick <= 1'b1;
		aux_run("aux1 peripheral", 1, 8);
		bus(1'b1, 5'h0c, 32'h30);
		aux_run("aux1 divided", 1, 2);
		bus(1'b1, 5'h08, 32'h104);
		peripheralPllTick <= 1'b0;
		corePllTick <= 1'b1;
		aux_run("aux1 core", 1, 2);
	endtask : t_aux

	task automatic t_boot00();
		por_assert();
		bus(1'b1, 5'h08, 32'h0);
		por_release(2'h0);
		repeat (30) @(negedge core_clk);
		chk("req oe crystal", 0, padOe);
		@(posedge core_clk);
		extDrive <= 1'b1;
		extLevel <= 1'b1;
		aux_run("aux0 pin request", 0, 4);
		@(posedge core_clk);
		extLevel <= 1'b0;
		aux_run("aux0 pin idle", 0, 0);
	endtask : t_boot00

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (10000) @(posedge core_clk);
		errors++;
		final_report();
	end

	initial begin
		errors = 0;
		samples_checked = 0;
		rstn = 1'b0;
		{read, write, porRelease, pullUp, extDrive, extLevel, peripheralPllTick, corePllTick} = 8'h00;
		{auxClkRequest1, ballIn} = 2'h3;
		address = 5'h00;
		writedata = 32'h0;
		byteenable = 4'hf;
		bootCfg = 2'h1;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_osc();
		t_abort();
		t_powerup();
		t_aux();
		t_boot00();
		final_report();
	end
endmodule : tb_reset_and_refclk_request_ctrl
